// [dv/serial_host_model.sv]
// Host model that drives byte accesses into the charger register bank
module serial_host_model (
   // Clock
   input wire logic sys_clk,
   // Byte access port toward the bank
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle port at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end
   // One access: drive after an edge, one edge takes it, then sample the answer
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ak);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = wr;
      reg_rd = !wr;
      @(posedge sys_clk);
      #1;
      q = reg_rdata;
      ak = reg_ack;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = ~a;  // Released lines carry no stale value
      reg_wdata = ~d;
   endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the charger current-setting register bank
module testbench import chg_cur_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q, a, d, m12, m13, m14;
   logic reg_wr, reg_rd, reg_ack, reg_hit, reg_wr_refused, ak, map, ok;
   logic [4:0] charger_lock_key = 5'h00;
   logic [5:0] topoff_current_code, precharge_current_code;
   logic [6:0] topoff_current_ma, precharge_current_ma;
   logic [1:0] ctl4_reserved_bits;
   logic [31:0] seed = 32'h00012C14;
   int num_errors = 0;
   int check_count = 0;
   // Clock at 8 ns
   always #4 sys_clk = ~sys_clk;
   charger_current_setting_regs u_charger_current_setting_regs (.sys_clk(sys_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_hit(reg_hit),
      .reg_wr_refused(reg_wr_refused), .charger_lock_key(charger_lock_key),
      .topoff_current_code(topoff_current_code), .precharge_current_code(precharge_current_code),
      .topoff_current_ma(topoff_current_ma), .precharge_current_ma(precharge_current_ma),
      .ctl4_reserved_bits(ctl4_reserved_bits));
   serial_host_model u_serial_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack));
   // Expectation helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_read(input logic [7:0] ad);
      return (ad == 8'h12) ? m12 : (ad == 8'h13) ? m13 : (ad == 8'h14) ? m14 : 8'h00;
   endfunction
   function automatic logic [7:0] exp_ma(input logic [7:0] r);
      return {2'h0, r[5:0]};  // One milliampere per code step
   endfunction
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
   // Main sequence: reset reads, then random writes with corners and read-back
   initial begin
      m12 = 8'h04;
      m13 = {2'h0, PRECHG_RST};
      m14 = 8'h00;
      repeat (10) @(posedge sys_clk);
      #1 rst = 1'h0;
      check("reset topoff ma", 8'h04, {1'h0, topoff_current_ma});
      check("reset prechg code", m13, {2'h0, precharge_current_code});
      for (int i = 0; i < 4; i++) begin
         u_serial_host_model.access(1'h0, 8'h12 + 8'(i), 8'h00, q, ak);
         check("reset read", exp_read(8'h12 + 8'(i)), q);
      end
      for (int i = 0; i < 60; i++) begin
         seed = lfsr_next(seed);
         a = (i < 6) ? 8'h12 + 8'(i % 3) : 8'h11 + {6'h0, seed[9:8]};
         d = (i < 6) ? {8{i[0]}} : seed[7:0];
         @(posedge sys_clk);
         #1 charger_lock_key = (i < 6 || seed[12]) ? UNLOCK_KEY : seed[20:16];
         map = (a >= 8'h12) && (a <= 8'h14);
         ok = map && (charger_lock_key === 5'h15);
         u_serial_host_model.access(1'h1, a, d, q, ak);
         check("write ack", 8'h01, {7'h0, ak});
         check("write hit", {7'h0, map}, {7'h0, reg_hit});
         check("write refused", {7'h0, map && !ok}, {7'h0, reg_wr_refused});
         if (ok && a == 8'h12) m12 = d;
         if (ok && a == 8'h13) m13 = d;
         if (ok && a == 8'h14) m14 = {d[7:6], 6'h00};
         check("topoff code", {2'h0, m12[5:0]}, {2'h0, topoff_current_code});
         check("topoff ma", exp_ma(m12), {1'h0, topoff_current_ma});
         check("prechg code", {2'h0, m13[5:0]}, {2'h0, precharge_current_code});
         check("prechg ma", exp_ma(m13), {1'h0, precharge_current_ma});
         check("ctl4 bits", {6'h0, m14[7:6]}, {6'h0, ctl4_reserved_bits});
         u_serial_host_model.access(1'h0, a, 8'h00, q, ak);
         check("read data", exp_read(a), q);
         check("read ack", 8'h01, {7'h0, ak});
      end
      // Mid-run reset brings every register back to its default
      @(posedge sys_clk);
      #1 rst = 1'h1;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'h0;
      m12 = 8'h04;
      m13 = {2'h0, PRECHG_RST};
      m14 = 8'h00;
      check("re-reset topoff code", 8'h04, {2'h0, topoff_current_code});
      for (int i = 0; i < 3; i++) begin
         u_serial_host_model.access(1'h0, 8'h12 + 8'(i), 8'h00, q, ak);
         check("re-reset read", exp_read(8'h12 + 8'(i)), q);
      end
      report_and_stop();
   end
endmodule

// [inc/chg_cur_pkg.sv]
// Constants and types for the charger current-setting register bank
package chg_cur_pkg;

   // ***************************************************************
   // Register addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_TOPOFF = 8'h12;
   localparam logic [7:0] ADDR_PRECHG = 8'h13;
   localparam logic [7:0] ADDR_CTL4 = 8'h14;

   // ***************************************************************
   // Field layout
   // ***************************************************************
   localparam int CODE_W = 6;
   localparam int CODE_LSB = 0;
   localparam int CODE_MSB = 5;
   localparam int RESERVED_BITS_LSB = 6;
   localparam int RESERVED_BITS_MSB = 7;
   localparam int RESERVED_BITS_W = 2;
   localparam int MA_W = 7;

   // ***************************************************************
   // Reset values and lock pattern
   // ***************************************************************
   localparam logic [5:0] TOPOFF_RST = 6'h04;
   localparam logic [5:0] PRECHG_RST = 6'h04;
   localparam logic [1:0] RESERVED_BITS_RST = 2'h0;
   localparam logic [4:0] UNLOCK_KEY = 5'h15;
   localparam logic [7:0] READ_NONE = 8'h00;

   // Current step in milliamperes per code step
   localparam logic [6:0] MA_PER_STEP = 7'h01;

   // Whole state of the bank
   typedef struct packed {
      logic [5:0] topoff_code_r;
      logic [1:0] topoff_reserved_bits_r;
      logic [5:0] prechg_code_r;
      logic [1:0] prechg_reserved_bits_r;
      logic [1:0] ctl4_reserved_bits_r;
      logic [6:0] topoff_ma_r;
      logic [6:0] prechg_ma_r;
      logic [7:0] rdata_r;
      logic ack_r;
      logic hit_r;
      logic refused_r;
   } bank_state_t;

endpackage

// [rtl/charger_current_setting_regs.sv]
// Charger current-setting register bank behind the serial register port

// Notes on behaviour
// - Address 12h holds the top-off current code in bits 5:0 and two read/write spare bits above.
// - The top-off code means one milliampere per step, 00h is 0 mA and 3Fh is 63 mA.
// - After reset the top-off code is 04h, which is 4 mA.
// - Address 13h holds the pre-charge current code in bits 5:0 and two read/write spare bits.
// - The pre-charge code means one milliampere per step, from 0 mA up to 63 mA.
// - The pre-charge default is ambiguous, and this bank resets it to 04h, which is 4 mA.
// - Addresses 12h, 13h and 14h always read, and write only while the lock key permits.
// - Writes are permitted only while the five-bit lock key equals 10101.
// - A write made while locked is dropped and the register keeps its old contents.
module charger_current_setting_regs
   import chg_cur_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Byte access from the serial bus engine
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_ack,
   output logic reg_hit,
   output logic reg_wr_refused,
   // Lock key from the charger control register
   input wire logic [4:0] charger_lock_key,
   // Settings to the charger
   output logic [5:0] topoff_current_code,
   output logic [5:0] precharge_current_code,
   output logic [6:0] topoff_current_ma,
   output logic [6:0] precharge_current_ma,
   output logic [1:0] ctl4_reserved_bits
);

   // ***************************************************************
   // Helpers
   // ***************************************************************

   // Code to milliamperes, linear at one step per mA
   function automatic logic [6:0] code_to_ma(input logic [5:0] code);
      logic [13:0] prod;
      prod = 14'({1'b0, code}) * 14'(MA_PER_STEP);
      return prod[MA_W-1:0];
   endfunction

   // True when the address falls on one of the three registers
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == ADDR_TOPOFF) || (a == ADDR_PRECHG) || (a == ADDR_CTL4);
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   bank_state_t st_r;
   bank_state_t st_nxt;
   logic unlocked;

   // Lock key compare
   assign unlocked = (charger_lock_key == UNLOCK_KEY);

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack_r = 1'b0;
      st_nxt.refused_r = 1'b0;
      // Writes: whole byte in one cycle (bits 7:6 only at 14h), only when unlocked
      if (reg_wr && is_mapped(reg_addr)) begin
         if (unlocked) begin
            unique case (reg_addr)
               ADDR_TOPOFF: begin
                  st_nxt.topoff_code_r = reg_wdata[CODE_MSB:CODE_LSB];
                  st_nxt.topoff_reserved_bits_r = reg_wdata[RESERVED_BITS_MSB:RESERVED_BITS_LSB];
               end
               ADDR_PRECHG: begin
                  st_nxt.prechg_code_r = reg_wdata[CODE_MSB:CODE_LSB];
                  st_nxt.prechg_reserved_bits_r = reg_wdata[RESERVED_BITS_MSB:RESERVED_BITS_LSB];
               end
               default: begin
                  st_nxt.ctl4_reserved_bits_r = reg_wdata[RESERVED_BITS_MSB:RESERVED_BITS_LSB];
               end
            endcase
         end else begin
            st_nxt.refused_r = 1'b1;
         end
      end
      // Answer for every access, mapped or not
      if (reg_wr || reg_rd) begin
         st_nxt.ack_r = 1'b1;
         st_nxt.hit_r = is_mapped(reg_addr);
      end
      // Reads always allowed; unmapped reads give zero
      if (reg_rd) begin
         if (reg_addr == ADDR_TOPOFF) begin
            st_nxt.rdata_r = {st_r.topoff_reserved_bits_r, st_r.topoff_code_r};
         end else if (reg_addr == ADDR_PRECHG) begin
            st_nxt.rdata_r = {st_r.prechg_reserved_bits_r, st_r.prechg_code_r};
         end else if (reg_addr == ADDR_CTL4) begin
            st_nxt.rdata_r = {st_r.ctl4_reserved_bits_r, {CODE_W{1'b0}}};
         end else begin
            st_nxt.rdata_r = READ_NONE;
         end
      end
      // Current decode follows the stored codes
      st_nxt.topoff_ma_r = code_to_ma(st_nxt.topoff_code_r);
      st_nxt.prechg_ma_r = code_to_ma(st_nxt.prechg_code_r);
   end

   // Registers, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r.topoff_code_r <= TOPOFF_RST;
         st_r.topoff_reserved_bits_r <= RESERVED_BITS_RST;
         st_r.prechg_code_r <= PRECHG_RST;
         st_r.prechg_reserved_bits_r <= RESERVED_BITS_RST;
         st_r.ctl4_reserved_bits_r <= RESERVED_BITS_RST;
         st_r.topoff_ma_r <= code_to_ma(TOPOFF_RST);
         st_r.prechg_ma_r <= code_to_ma(PRECHG_RST);
         st_r.rdata_r <= READ_NONE;
         st_r.ack_r <= 1'b0;
         st_r.hit_r <= 1'b0;
         st_r.refused_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state flops
   assign reg_rdata = st_r.rdata_r;
   assign reg_ack = st_r.ack_r;
   assign reg_hit = st_r.hit_r;
   assign reg_wr_refused = st_r.refused_r;
   assign topoff_current_code = st_r.topoff_code_r;
   assign precharge_current_code = st_r.prechg_code_r;
   assign topoff_current_ma = st_r.topoff_ma_r;
   assign precharge_current_ma = st_r.prechg_ma_r;
   assign ctl4_reserved_bits = st_r.ctl4_reserved_bits_r;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // Unlocked write to a given address
   sequence wr_ok_s(logic [7:0] a);
      reg_wr && !reg_rd && unlocked && reg_addr == a;
   endsequence

   // Locked write to a mapped address
   sequence wr_locked_s;
      reg_wr && !unlocked && is_mapped(reg_addr);
   endsequence

   topoff_write_a: assert property (
      wr_ok_s(ADDR_TOPOFF) |=> topoff_current_code == $past(reg_wdata[CODE_MSB:CODE_LSB]))
      else $error("top-off code not taken from write");

   topoff_ma_a: assert property (
      topoff_current_ma == {1'b0, topoff_current_code})
      else $error("top-off current decode wrong");

   topoff_reset_a: assert property (
      $fell(rst) |-> topoff_current_code == TOPOFF_RST && precharge_current_code == PRECHG_RST)
      else $error("code default wrong after reset");

   prechg_write_a: assert property (
      wr_ok_s(ADDR_PRECHG) |=> precharge_current_code == $past(reg_wdata[CODE_MSB:CODE_LSB]))
      else $error("pre-charge code not taken from write");

   prechg_ma_a: assert property (
      precharge_current_ma == {1'b0, precharge_current_code})
      else $error("pre-charge current decode wrong");

   read_back_a: assert property (
      reg_rd && !reg_wr && reg_addr == ADDR_PRECHG |=> reg_ack && reg_hit
         && reg_rdata == {$past(st_r.prechg_reserved_bits_r), $past(precharge_current_code)})
      else $error("pre-charge read-back wrong");

   lock_key_a: assert property (
      reg_wr && reg_addr == ADDR_CTL4 && charger_lock_key != UNLOCK_KEY
         |=> $stable(ctl4_reserved_bits) && reg_wr_refused)
      else $error("write accepted with wrong key");

   locked_keep_a: assert property (
      wr_locked_s |=> $stable(topoff_current_code) && $stable(precharge_current_code)
         && $stable(ctl4_reserved_bits) && reg_wr_refused)
      else $error("locked write changed a register");

   whole_byte_a: assert property (
      wr_ok_s(ADDR_TOPOFF) |=> {st_r.topoff_reserved_bits_r, topoff_current_code} == $past(reg_wdata)
         && !reg_wr_refused)
      else $error("write not applied as whole byte");

   // Any access on the byte port, read or write
   sequence access_s;
      reg_wr || reg_rd;
   endsequence

   // Every access is answered on the next edge, with the decoded hit
   access_ack_a: assert property (
      access_s |=> reg_ack && reg_hit == $past(is_mapped(reg_addr)))
      else $error("access not answered on the next cycle");

   // No answer and no refusal without a request
   idle_quiet_a: assert property (
      !reg_wr && !reg_rd |=> !reg_ack && !reg_wr_refused)
      else $error("answer seen without a request");

   // The right key never refuses a write
   key_accept_a: assert property (
      reg_wr && unlocked |=> !reg_wr_refused)
      else $error("write refused with the unlock key");

   // Spare bits of the third register follow an unlocked write
   ctl4_write_a: assert property (
      wr_ok_s(ADDR_CTL4) |=> ctl4_reserved_bits == $past(reg_wdata[RESERVED_BITS_MSB:RESERVED_BITS_LSB]))
      else $error("spare bits not taken from write");

   // Reads off the map give the empty byte and no hit
   unmapped_read_a: assert property (
      reg_rd && !is_mapped(reg_addr) |=> reg_rdata == READ_NONE && !reg_hit)
      else $error("unmapped read gave data");

endmodule
